// ==== hw/fod_unit.sv ====
// Function
// [RULE1] Misaligned wide register raises bad-alignment trap
// [RULE2] Double pair: even half high, odd low
// [RULE3] Quad group: suffixes 00..11 from high
// [RULE4] Result sized to destination precision
// [RULE5] Non-compares return five-bit trial exceptions
// [RULE6] Compares return two-bit trial condition code
// [RULE7] Every operation returns a completion flag
// [RULE8] Integer-to-float reads one single register
// [RULE9] Float-to-integer reads single, pair or group
// [RULE10] Six format conversions, source in own format
// [RULE11] Copy, negate, magnitude exact; no exceptions
// [RULE12] Square root uses second source only
// [RULE13] Add/subtract in one precision throughout
// [RULE14] Multiply/divide plus two widening multiplies
// [RULE15] Quiet and signalling compares write nothing
// [RULE16] Codes: equal 0, less 1, greater 2, unordered 3
// [RULE17] Result, exceptions, flag presented together
`timescale 1ns/10ps
`include "fod_map.svh"
module fod_unit #(
    parameter logic [2:0] BAD_ALIGNMENT_CODE = 3'h1
) (
    // Clock and reset
    input  wire logic           clk_in,
    input  wire logic           rst_in,
    // APB slave
    input  wire logic           psel_in,
    input  wire logic           penable_in,
    input  wire logic           pwrite_in,
    input  wire logic [11:0]    paddr_in,
    input  wire logic [31:0]    pwdata_in,
    output logic [31:0]         prdata_out,
    output logic                pready_out,
    output logic                pslverr_out,
    // Pipeline side
    input  wire fod_pkg::fod_req_t  req_in,
    input  wire fod_pkg::fod_load_t load_in,
    // Status and trap side
    output fod_pkg::fod_resp_t  resp_out,
    output logic                float_trap_request_out
);
    import fod_pkg::*;

    // ==========================================
    // State
    logic [31:0] fregs [32];
    logic        align_trap_en;
    logic [31:0] op_count;
    fod_fmt_t    fmt;
    logic        misaligned;
    fod_resp_t   next_resp;
    logic [127:0] opa;
    logic [127:0] opb;
    logic [127:0] opb_q;
    fod_op_t     op_q;
    fod_resp_t   last_resp;

    // ==========================================
    // Operand formats per operation
    function automatic fod_fmt_t fmt_of(input fod_op_t op);
        fod_fmt_t f;
        f = '{P_NONE, P_NONE, P_NONE};
        case (op)
            OP_COPY, OP_NEG, OP_MAG, OP_ITOS, OP_STOI, OP_SQRTS: f = '{P_NONE, P_S, P_S};
            OP_ITOD, OP_STOD:          f = '{P_NONE, P_S, P_D};
            OP_ITOQ, OP_STOQ:          f = '{P_NONE, P_S, P_Q};
            OP_DTOI, OP_DTOS:          f = '{P_NONE, P_D, P_S};
            OP_QTOI, OP_QTOS:          f = '{P_NONE, P_Q, P_S};
            OP_DTOQ:                   f = '{P_NONE, P_D, P_Q};
            OP_QTOD:                   f = '{P_NONE, P_Q, P_D};
            OP_SQRTD:                  f = '{P_NONE, P_D, P_D};
            OP_SQRTQ:                  f = '{P_NONE, P_Q, P_Q};
            OP_ADDS, OP_SUBS, OP_MULS, OP_DIVS: f = '{P_S, P_S, P_S};
            OP_ADDD, OP_SUBD, OP_MULD, OP_DIVD: f = '{P_D, P_D, P_D};
            OP_ADDQ, OP_SUBQ, OP_MULQ, OP_DIVQ: f = '{P_Q, P_Q, P_Q};
            OP_WMULS:                  f = '{P_S, P_S, P_D};
            OP_WMULD:                  f = '{P_D, P_D, P_Q};
            OP_CMPS, OP_CMPES:         f = '{P_S, P_S, P_NONE};
            OP_CMPD, OP_CMPED:         f = '{P_D, P_D, P_NONE};
            OP_CMPQ, OP_CMPEQ:         f = '{P_Q, P_Q, P_NONE};
            default:                   f = '{P_NONE, P_NONE, P_NONE};
        endcase
        return f;
    endfunction : fmt_of

    function automatic logic bad_spec(input logic [4:0] s, input fod_prec_t p);
        return ((p == P_D) && s[0]) || ((p == P_Q) && (s[1:0] != 2'b00));
    endfunction : bad_spec

    // Wide operands are left-aligned so one compare serves every format
    function automatic logic [127:0] gather(input logic [4:0] s, input fod_prec_t p);
        logic [127:0] v;
        v = 128'h0;
        case (p)
            P_S: v = {fregs[s], 96'h0};
            // [RULE2] even half high
            P_D: v = {fregs[{s[4:1], 1'b0}], fregs[{s[4:1], 1'b1}], 64'h0};
            // [RULE3] four in order
            P_Q: v = {fregs[{s[4:2], 2'b00}], fregs[{s[4:2], 2'b01}],
                      fregs[{s[4:2], 2'b10}], fregs[{s[4:2], 2'b11}]};
            default: v = 128'h0;
        endcase
        return v;
    endfunction : gather

    function automatic logic is_nan(input logic [127:0] x, input fod_prec_t p);
        case (p)
            P_S: return (x[126:119] == 8'hFF) && (x[118:96] != 23'h0);
            P_D: return (x[126:116] == 11'h7FF) && (x[115:64] != 52'h0);
            P_Q: return (x[126:112] == 15'h7FFF) && (x[111:0] != 112'h0);
            default: return 1'b0;
        endcase
    endfunction : is_nan

    function automatic logic is_snan(input logic [127:0] x, input fod_prec_t p);
        case (p)
            P_S: return is_nan(x, p) && !x[118];
            P_D: return is_nan(x, p) && !x[115];
            P_Q: return is_nan(x, p) && !x[111];
            default: return 1'b0;
        endcase
    endfunction : is_snan

    // [RULE16] condition encoding
    function automatic logic [1:0] compare(input logic [127:0] a, input logic [127:0] b,
                                           input fod_prec_t p);
        logic [127:0] ka;
        logic [127:0] kb;
        ka = a[127] ? ~a : {1'b1, a[126:0]};
        kb = b[127] ? ~b : {1'b1, b[126:0]};
        if (is_nan(a, p) || is_nan(b, p)) begin
            return `FOD_FCC_UN;
        end
        // Plus and minus zero compare equal
        if ((a[126:0] == 127'h0) && (b[126:0] == 127'h0)) begin
            return `FOD_FCC_EQ;
        end
        if (ka == kb) begin
            return `FOD_FCC_EQ;
        end
        return (ka < kb) ? `FOD_FCC_LT : `FOD_FCC_GT;
    endfunction : compare

    // ==========================================
    // Dispatch
    always_comb begin
        fmt = fmt_of(req_in.op);
        // [RULE1] alignment check
        misaligned = bad_spec(req_in.rs1, fmt.a) || bad_spec(req_in.rs2, fmt.b)
                     || bad_spec(req_in.rd, fmt.d);
        // [RULE12] second source only
        opa = gather(req_in.rs1, fmt.a);
        opb = gather(req_in.rs2, fmt.b);
        next_resp = '0;
        next_resp.done = req_in.valid;
        // [RULE4] destination size
        next_resp.size = fmt.d;
        case (req_in.op)
            // [RULE11] exact moves
            OP_COPY: begin
                next_resp.result = opb;
                next_resp.c = 1'b1;
            end
            OP_NEG: begin
                next_resp.result = {opb[127:96] ^ `FOD_SIGN_FLIP, 96'h0};
                next_resp.c = 1'b1;
            end
            OP_MAG: begin
                next_resp.result = {opb[127:96] & `FOD_SIGN_CLEAR, 96'h0};
                next_resp.c = 1'b1;
            end
            // [RULE15] compares
            OP_CMPS, OP_CMPD, OP_CMPQ, OP_CMPES, OP_CMPED, OP_CMPEQ: begin
                next_resp.is_cmp = 1'b1;
                // [RULE6] trial condition code
                next_resp.tfcc = compare(opa, opb, fmt.a);
                next_resp.c = 1'b1;
                if (req_in.op inside {OP_CMPES, OP_CMPED, OP_CMPEQ}) begin
                    next_resp.texc[`FOD_EXC_NV] = is_nan(opa, fmt.a) || is_nan(opb, fmt.a);
                end else begin
                    next_resp.texc[`FOD_EXC_NV] = is_snan(opa, fmt.a) || is_snan(opb, fmt.a);
                end
            end
            // [RULE8] [RULE9] [RULE10] [RULE13] [RULE14]
            // Rounding arithmetic is not built in: the flag reports
            // unfinished so trap software completes the operation.
            default: begin
                next_resp.result = 128'h0;
                next_resp.c = 1'b0;
            end
        endcase
        if (misaligned && align_trap_en) begin
            next_resp.trap = 1'b1;
            next_resp.trap_type = BAD_ALIGNMENT_CODE;
            next_resp.c = 1'b0;
            next_resp.result = 128'h0;
            next_resp.tfcc = 2'b00;
            next_resp.texc = 5'h00;
        end
        if (!req_in.valid) begin
            next_resp = '0;
        end
    end

    // ==========================================
    // Response register
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            resp_out <= '0;
            float_trap_request_out <= 1'b0;
            opb_q <= 128'h0;
            op_q <= OP_COPY;
        end else begin
            // [RULE17] one cycle, all together
            // [RULE5] [RULE7] vector and flag
            resp_out <= next_resp;
            // [RULE1] trap request
            float_trap_request_out <= next_resp.trap;
            opb_q <= opb;
            op_q <= req_in.op;
        end
    end

    // Status keeps the last answer; the response itself is a one-cycle pulse
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            last_resp <= '0;
        end else if (next_resp.done) begin
            last_resp <= next_resp;
        end
    end

    // ==========================================
    // Register file: pipeline loads, then results
    always_ff @(posedge clk_in) begin
        if (load_in.we) begin
            fregs[load_in.addr] <= load_in.data;
        end
        // Writeback wins a same-register clash with a load
        for (int i = 0; i < 4; i++) begin
            if (next_resp.done && next_resp.c && !next_resp.trap && !next_resp.is_cmp
                && ((next_resp.size == P_Q) || ((next_resp.size == P_D) && (i < 2))
                    || ((next_resp.size == P_S) && (i == 0)))) begin
                fregs[req_in.rd + 5'(i)] <= next_resp.result[127 - 32 * i -: 32];
            end
        end
    end

    // ==========================================
    // APB slave, one wait state
    logic apb_take;
    assign apb_take = psel_in && penable_in && pready_out;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            prdata_out <= 32'h0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= psel_in && penable_in && !pready_out;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0;
            case (paddr_in)
                `FOD_CTRL_OFS:  prdata_out <= {31'h0, align_trap_en};
                `FOD_STATUS_OFS: prdata_out <= {17'h0, last_resp.trap_type, 2'h0, last_resp.is_cmp,
                                                last_resp.trap, last_resp.c, last_resp.tfcc,
                                                last_resp.texc};
                `FOD_COUNT_OFS: prdata_out <= op_count;
                default:        pslverr_out <= psel_in && penable_in && !pready_out;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            align_trap_en <= 1'(`FOD_CTRL_RESET);
        end else if (apb_take && pwrite_in && (paddr_in == `FOD_CTRL_OFS)) begin
            align_trap_en <= pwdata_in[`FOD_CTRL_TRAPEN];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            op_count <= 32'h0;
        end else if (resp_out.done) begin
            op_count <= op_count + 32'h1;
        end
    end

    // ==========================================
    // Checks
    sequence s_taken;
        req_in.valid;
    endsequence
    sequence s_answered;
        ##1 resp_out.done;
    endsequence

    // [RULE7] answer next cycle
    a_done_next_cycle: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE7]
        s_taken |-> s_answered) else $error("operation not answered");
    // [RULE1] odd double traps
    a_misalign_trap: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE1]
        req_in.valid && align_trap_en && (req_in.op == OP_ADDD) && req_in.rs2[0]
        |=> float_trap_request_out && resp_out.trap_type == BAD_ALIGNMENT_CODE && !resp_out.c)
        else $error("misaligned double did not trap");
    // [RULE17] trap and response agree
    a_trap_in_step: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE17]
        float_trap_request_out == (resp_out.done && resp_out.trap))
        else $error("trap request out of step");
    // [RULE11] negate flips sign
    a_negate_sign: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE11]
        resp_out.done && !resp_out.trap && op_q == OP_NEG
        |-> resp_out.result[127:96] == (opb_q[127:96] ^ `FOD_SIGN_FLIP) && resp_out.c
            && resp_out.texc == 5'h00) else $error("negate result wrong");
    // [RULE11] magnitude clears sign
    a_magnitude_sign: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE11]
        resp_out.done && !resp_out.trap && op_q == OP_MAG
        |-> !resp_out.result[127] && resp_out.result[126:96] == opb_q[126:96])
        else $error("magnitude result wrong");
    // [RULE15] compare has no data
    a_compare_no_data: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE15]
        resp_out.done && resp_out.is_cmp |-> resp_out.size == P_NONE && resp_out.result == 128'h0)
        else $error("compare produced data");
    // [RULE16] equal operands
    a_equal_code: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE16]
        req_in.valid && align_trap_en && req_in.op == OP_CMPS && req_in.rs1 == req_in.rs2
        && !is_nan(opa, P_S) |=> resp_out.tfcc == `FOD_FCC_EQ)
        else $error("equal compare wrong code");
    // [RULE4] quad size from quad op
    a_quad_size: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE4]
        req_in.valid && req_in.op == OP_DTOQ |=> resp_out.size == P_Q)
        else $error("quad destination size wrong");
    // [RULE6] code only on compares
    a_code_only_cmp: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE6]
        resp_out.done && !resp_out.is_cmp |-> resp_out.tfcc == 2'b00)
        else $error("condition code outside compare");
    // [RULE5] count follows answers
    a_count_step: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE5]
        resp_out.done |=> op_count == $past(op_count) + 32'h1)
        else $error("operation count stalled");
    // [RULE17] status holds last answer
    a_status_latch: assert property (@(posedge clk_in) disable iff (rst_in) // [RULE17]
        resp_out.done |-> last_resp == resp_out)
        else $error("status lost last answer");
endmodule : fod_unit

// ==== hw/fod_map.svh ====
`ifndef FOD_MAP_SVH
`define FOD_MAP_SVH
// ==========================================
// APB register offsets
`define FOD_CTRL_OFS      12'h000
`define FOD_STATUS_OFS    12'h004
`define FOD_COUNT_OFS     12'h008
// ==========================================
// Field positions and reset values
`define FOD_CTRL_TRAPEN   0
`define FOD_CTRL_RESET    32'h0000_0001
`define FOD_ST_TEXC_LSB   0
`define FOD_ST_FCC_LSB    5
`define FOD_ST_DONE_BIT   7
`define FOD_ST_TRAP_BIT   8
`define FOD_ST_CMP_BIT    9
`define FOD_ST_FTT_LSB    12
// ==========================================
// Trial exception vector bits
`define FOD_EXC_NV        4
// ==========================================
// Condition codes and sign masks
`define FOD_FCC_EQ        2'h0
`define FOD_FCC_LT        2'h1
`define FOD_FCC_GT        2'h2
`define FOD_FCC_UN        2'h3
`define FOD_SIGN_FLIP     32'h8000_0000
`define FOD_SIGN_CLEAR    32'h7FFF_FFFF
`endif

// ==== hw/fod_pkg.sv ====
package fod_pkg;
    // ==========================================
    // Operations issued by the pipeline
    typedef enum logic [5:0] {
        OP_COPY, OP_NEG, OP_MAG,
        OP_ITOS, OP_ITOD, OP_ITOQ, OP_STOI, OP_DTOI, OP_QTOI,
        OP_STOD, OP_STOQ, OP_DTOS, OP_DTOQ, OP_QTOS, OP_QTOD,
        OP_SQRTS, OP_SQRTD, OP_SQRTQ,
        OP_ADDS, OP_ADDD, OP_ADDQ, OP_SUBS, OP_SUBD, OP_SUBQ,
        OP_MULS, OP_MULD, OP_MULQ, OP_WMULS, OP_WMULD,
        OP_DIVS, OP_DIVD, OP_DIVQ,
        OP_CMPS, OP_CMPD, OP_CMPQ, OP_CMPES, OP_CMPED, OP_CMPEQ
    } fod_op_t;
    typedef enum logic [1:0] {P_NONE, P_S, P_D, P_Q} fod_prec_t;
    typedef struct packed {
        fod_prec_t a;
        fod_prec_t b;
        fod_prec_t d;
    } fod_fmt_t;
    typedef struct packed {
        logic      valid;
        fod_op_t   op;
        logic [4:0] rs1;
        logic [4:0] rs2;
        logic [4:0] rd;
    } fod_req_t;
    typedef struct packed {
        logic       we;
        logic [4:0] addr;
        logic [31:0] data;
    } fod_load_t;
    typedef struct packed {
        logic        done;
        logic        c;
        logic        trap;
        logic [2:0]  trap_type;
        logic [4:0]  texc;
        logic [1:0]  tfcc;
        logic        is_cmp;
        fod_prec_t   size;
        logic [127:0] result;
    } fod_resp_t;
endpackage : fod_pkg

// ==== verification/fod_pipe_model.sv ====
`timescale 1ns/10ps
module fod_pipe_model (
    // Clock
    input  wire logic               clk_in,
    // Toward the unit
    output fod_pkg::fod_req_t       req_out,
    output fod_pkg::fod_load_t      load_out,
    // From the unit
    input  wire fod_pkg::fod_resp_t resp_in,
    input  wire logic               trap_in
);
    import fod_pkg::*;
    initial begin
        req_out = '0;
        load_out = '0;
    end
    // ==========================================
    // Loads and issues
    // Idle fields inverted so stale specifiers never pass as live
    task automatic load_reg(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_in);
        load_out <= '{1'b1, a, d};
        @(posedge clk_in);
        load_out <= '{1'b0, ~a, ~d};
    endtask : load_reg
    task automatic issue(input fod_op_t op, input logic [4:0] a, b, d,
                         output fod_resp_t r, output logic t, output logic late);
        @(posedge clk_in);
        req_out <= '{1'b1, op, a, b, d};
        @(posedge clk_in);
        req_out <= '{1'b0, fod_op_t'(~op), ~a, ~b, ~d};
        @(negedge clk_in);
        r = resp_in;
        t = trap_in;
        @(negedge clk_in);
        late = resp_in.done;
    endtask : issue
endmodule : fod_pipe_model

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
`include "fod_map.svh"
module testbench;
    import fod_pkg::*;
    localparam logic [2:0] BAD_CODE = 3'h1;
    localparam int         LIMIT    = 4000;
    logic        clk_in     = 1'b0;
    logic        rst_in     = 1'b1;
    logic        psel_in    = 1'b0;
    logic        penable_in = 1'b0;
    logic        pwrite_in  = 1'b0;
    logic [11:0] paddr_in   = '0;
    logic [31:0] pwdata_in  = '0;
    logic [31:0] prdata_out;
    logic        pready_out;
    logic        pslverr_out;
    fod_req_t    req;
    fod_load_t   load;
    fod_resp_t   resp_out;
    logic        trap_req;
    fod_resp_t   r;
    logic        tr;
    logic        late;
    logic [31:0] rdat;
    logic        rerr;
    int          mismatches = 0;
    int          cmp_count  = 0;
    int          cycles     = 0;
    int          n_ops      = 0;
    // Low words disagree with high words, so swapped halves flip the order
    logic [31:0] init_f [17] = '{32'h3FF0_0000, 32'h0000_0009, 32'h4000_0000, 32'h0000_0001,
        32'h3F80_0000, 32'h4000_0000, 32'h7FC0_0000, 32'hBF80_0000, 32'h3FFF_0000, 32'h0,
        32'h0, 32'h0000_0009, 32'h4000_0000, 32'h0, 32'h0, 32'h0000_0001, 32'h1234_5678};

    always #5 clk_in = ~clk_in;

    fod_unit #(.BAD_ALIGNMENT_CODE(BAD_CODE)) i_fod_unit (
        .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .req_in(req), .load_in(load), .resp_out(resp_out), .float_trap_request_out(trap_req));
    fod_pipe_model i_fod_pipe_model (
        .clk_in(clk_in), .req_out(req), .load_out(load), .resp_in(resp_out), .trap_in(trap_req));

    // ==========================================
    // Verdict and hang guard
    task automatic conclude();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            mismatches++;
            conclude();
        end
    end
    task automatic check(input string what, input logic [127:0] exp, input logic [127:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // ==========================================
    // Register bus master
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= wd;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        pwdata_in <= ~wd;
        check("apb wait", 128'h2, 128'(n));
    endtask : apb

    // ==========================================
    // Operation kinds
    task automatic op(input fod_op_t o, input logic [4:0] a, b, d);
        i_fod_pipe_model.issue(o, a, b, d, r, tr, late);
        n_ops++;
        check("done", 1'b1, r.done);
        check("done pulse", 1'b0, late);
    endtask : op
    task automatic mv(input fod_op_t o, input logic [4:0] b, d, input logic [31:0] w);
        op(o, 5'h00, b, d);
        check("mv res", {w, 96'h0}, r.result);
        check("mv size", P_S, r.size);
        check("mv c texc", 6'h20, {r.c, r.texc});
        check("mv trap", 3'h0, {r.trap, tr, r.is_cmp});
    endtask : mv
    task automatic cmp(input fod_op_t o, input logic [4:0] a, b, input logic [1:0] cc, input logic nv);
        op(o, a, b, 5'h18);
        check("cmp fcc", cc, r.tfcc);
        check("cmp texc", 5'(nv) << `FOD_EXC_NV, r.texc);
        check("cmp flags", 4'hC, {r.c, r.is_cmp, r.trap, tr});
    endtask : cmp
    task automatic trp(input fod_op_t o, input logic [4:0] a, b, d);
        op(o, a, b, d);
        check("trap", 2'h3, {r.trap, tr});
        check("trap type", BAD_CODE, r.trap_type);
        check("trap c texc", 6'h00, {r.c, r.texc});
        check("trap res", 128'h0, r.result);
    endtask : trp

    // ==========================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        apb(1'b0, `FOD_CTRL_OFS, 32'h0, rdat, rerr);
        check("ctrl", `FOD_CTRL_RESET, rdat);
        apb(1'b0, `FOD_COUNT_OFS, 32'h0, rdat, rerr);
        check("count", 32'h0, rdat);
        apb(1'b0, 12'h00C, 32'h0, rdat, rerr);
        check("unmapped rd", 33'h1_0000_0000, {rerr, rdat});
        apb(1'b1, 12'h010, 32'hFFFF_FFFF, rdat, rerr);
        check("unmapped wr", 1'b1, rerr);
        foreach (init_f[i]) i_fod_pipe_model.load_reg(5'(i), init_f[i]);
        i_fod_pipe_model.load_reg(5'h18, 32'hA5A5_5A5A);
        mv(OP_COPY, 5'h07, 5'h14, 32'hBF80_0000);
        mv(OP_NEG, 5'h07, 5'h15, 32'h3F80_0000);
        mv(OP_MAG, 5'h07, 5'h16, 32'h3F80_0000);
        mv(OP_NEG, 5'h04, 5'h17, 32'hBF80_0000);
        mv(OP_MAG, 5'h04, 5'h1C, 32'h3F80_0000);
        mv(OP_COPY, 5'h15, 5'h19, 32'h3F80_0000);
        cmp(OP_CMPS, 5'h04, 5'h04, `FOD_FCC_EQ, 1'b0);
        cmp(OP_CMPS, 5'h04, 5'h05, `FOD_FCC_LT, 1'b0);
        cmp(OP_CMPS, 5'h05, 5'h04, `FOD_FCC_GT, 1'b0);
        cmp(OP_CMPES, 5'h07, 5'h04, `FOD_FCC_LT, 1'b0);
        cmp(OP_CMPD, 5'h00, 5'h02, `FOD_FCC_LT, 1'b0);
        cmp(OP_CMPED, 5'h02, 5'h00, `FOD_FCC_GT, 1'b0);
        cmp(OP_CMPQ, 5'h08, 5'h0C, `FOD_FCC_LT, 1'b0);
        cmp(OP_CMPEQ, 5'h0C, 5'h08, `FOD_FCC_GT, 1'b0);
        cmp(OP_CMPS, 5'h04, 5'h06, `FOD_FCC_UN, 1'b0);
        cmp(OP_CMPES, 5'h04, 5'h06, `FOD_FCC_UN, 1'b1);
        apb(1'b0, `FOD_STATUS_OFS, 32'h0, rdat, rerr);
        check("status cmp", 32'h0000_02F0, rdat);
        for (int k = OP_ITOS; k <= OP_DIVQ; k++) begin
            op(fod_op_t'(k), 5'h08, 5'h0C, 5'h10);
            check("ar flags", 4'h0, {r.c, r.trap, r.is_cmp, tr});
            check("ar res", 128'h0, r.result);
            check("ar texc", 5'h00, r.texc);
        end
        mv(OP_COPY, 5'h10, 5'h1A, 32'h1234_5678);
        mv(OP_COPY, 5'h18, 5'h1B, 32'hA5A5_5A5A);
        trp(OP_CMPD, 5'h01, 5'h02, 5'h00);
        trp(OP_QTOI, 5'h00, 5'h0D, 5'h00);
        trp(OP_MULD, 5'h00, 5'h02, 5'h11);
        trp(OP_ADDD, 5'h00, 5'h03, 5'h02);
        trp(OP_ADDQ, 5'h0A, 5'h08, 5'h04);
        trp(OP_DTOQ, 5'h00, 5'h03, 5'h04);
        apb(1'b1, `FOD_STATUS_OFS, 32'hFFFF_FFFF, rdat, rerr);
        apb(1'b0, `FOD_STATUS_OFS, 32'h0, rdat, rerr);
        check("status trap", 32'h0000_1100, rdat);
        apb(1'b1, `FOD_CTRL_OFS, 32'h0, rdat, rerr);
        cmp(OP_CMPD, 5'h01, 5'h02, `FOD_FCC_LT, 1'b0);
        cmp(OP_CMPQ, 5'h09, 5'h0E, `FOD_FCC_LT, 1'b0);
        apb(1'b1, `FOD_CTRL_OFS, `FOD_CTRL_RESET, rdat, rerr);
        trp(OP_SQRTD, 5'h00, 5'h03, 5'h00);
        apb(1'b0, `FOD_COUNT_OFS, 32'h0, rdat, rerr);
        check("count ops", 32'(n_ops), rdat);
        conclude();
    end
endmodule : testbench
